// [hdl/bsc_pkg.sv]
package bsc_pkg;

    // ------------------------------------------------------------
    // clock and switching-frequency limits
    // ------------------------------------------------------------
    localparam int          CLK_KHZ        = 125000;
    localparam int          CLK_PERIOD_NS  = 8;
    localparam int          FSW_MIN_KHZ    = 200;
    localparam int          FSW_MAX_KHZ    = 1600;
    // longest period is a floor, shortest a ceiling, so the range never leaves the window
    localparam logic [11:0] PERIOD_MAX_CYC = 12'(CLK_KHZ / FSW_MIN_KHZ);
    localparam logic [11:0] PERIOD_MIN_CYC = 12'((CLK_KHZ + FSW_MAX_KHZ - 1) / FSW_MAX_KHZ);
    localparam logic [11:0] RT_PERIOD_RST  = 12'h0B3;

    localparam int          LOSS_TIME_NS   = 10000;
    localparam logic [11:0] LOSS_CYC       = 12'((LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          MIN_OFF_NS     = 200;
    localparam logic [11:0] MIN_OFF_CYC    = 12'((MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [2:0]  DEAD_CYC       = 3'h2;
    localparam logic [9:0]  CLAMP_WAIT_CYC = 10'h200;
    localparam int          HICCUP_CYC_DEF = 16384;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_RT_PERIOD = 8'h04;
    localparam logic [7:0]  ADDR_STATUS    = 8'h08;
    localparam int          CTRL_FORCE_RT  = 0;
    localparam int          STS_EXT        = 0;
    localparam int          STS_ACTIVE     = 1;
    localparam int          STS_HICCUP     = 2;
    localparam int          STS_OVP_LOCK   = 3;
    localparam int          STS_SRC_SKIP   = 4;
    localparam int          STS_SINK_BLK   = 5;
    localparam int          STS_STATE_LSB  = 8;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_HS     = 7'h02,
        ST_DT_HL  = 7'h04,
        ST_LS     = 7'h08,
        ST_DT_LH  = 7'h10,
        ST_NONE   = 7'h20,
        ST_HICCUP = 7'h40
    } bsc_state_t;

    typedef struct packed {
        logic peak;
        logic src_lim;
        logic sink_lim;
        logic overvoltage_guard;
        logic below106;
        logic boot_uv;
        logic clamp;
        logic vin_ok;
        logic en_ok;
    } bsc_cmp_t;

    function automatic logic bsc_mapped(input logic [7:0] addr);
        bsc_mapped = (addr == ADDR_CTRL) || (addr == ADDR_RT_PERIOD) || (addr == ADDR_STATUS);
    endfunction : bsc_mapped

endpackage : bsc_pkg

// [hdl/bsc_osc_if.sv]
`timescale 1ns/1ps
interface bsc_osc_if;
    logic        sync_raw;
    logic        force_rt;
    logic [11:0] rt_period;
    logic        cycle_start;
    logic        ext_mode;
    logic        near_end;

    modport ctrl (output sync_raw, force_rt, rt_period, input cycle_start, ext_mode, near_end);
    modport osc  (input sync_raw, force_rt, rt_period, output cycle_start, ext_mode, near_end);
endinterface : bsc_osc_if

// [hdl/bsc_osc.sv]
`timescale 1ns/1ps
module bsc_osc
    import bsc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    bsc_osc_if.osc    o
);

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        logic        ext;
        logic [11:0] phase;
        logic [11:0] gap;
        logic [11:0] period;
        logic        cs;
        logic        near;
    } bsc_osc_st_t;

    bsc_osc_st_t q;
    bsc_osc_st_t n;
    logic        rise;
    logic        fall;
    logic        start;
    logic [11:0] eff_period;

    always_comb begin
        n    = q;
        n.s1 = o.sync_raw;
        n.s2 = q.s1;
        n.s3 = q.s2;
        rise = q.s2 & ~q.s3;
        fall = ~q.s2 & q.s3;
        if (rise || fall) begin
            n.gap = '0;
        end else if (q.gap < LOSS_CYC) begin
            n.gap = 12'(q.gap + 12'h001);
        end
        if (!q.ext) begin
            n.ext = rise & ~o.force_rt;
        end else if (o.force_rt || q.gap >= LOSS_CYC) begin
            n.ext = 1'b0;
        end
        if (q.ext) begin
            // without edges the cycle stretches to the slowest period, i.e. frequency drops
            start = fall || (q.phase >= 12'(PERIOD_MAX_CYC - 12'h001));
        end else begin
            start = q.phase >= 12'(o.rt_period - 12'h001);
        end
        if (q.ext && fall) begin
            n.period = 12'(q.phase + 12'h001);
        end
        n.cs    = start;
        n.phase = start ? 12'h000 : 12'(q.phase + 12'h001);
        eff_period = q.ext ? q.period : o.rt_period;
        n.near  = 12'(n.phase + MIN_OFF_CYC) >= eff_period;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o.cycle_start = q.cs;
    assign o.ext_mode    = q.ext;
    assign o.near_end    = q.near;

    a_loss_revert : assert property (@(posedge clk) disable iff (rst)
        (q.ext && q.gap >= LOSS_CYC) |=> !q.ext)
        else $error("sync mode kept after clock loss");

    a_fall_start : assert property (@(posedge clk) disable iff (rst)
        (q.ext && !q.s2 && q.s3) |=> q.cs)
        else $error("falling sync edge did not start a cycle");

endmodule : bsc_osc

// [hdl/bsc_top.sv]
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
// ------------------------------------------------------------
// switch-cycle supervisor top
// ------------------------------------------------------------
// Behaviour
// - internal oscillator frequency 200 to 1600 kHz
// - sync mode: cycle starts on falling edge
// - first rising sync edge enters sync mode
// - 10 us without edges returns to resistor mode
// - keep high side on near cycle end
// - bootstrap low forces low side on
// - overvoltage holds high side off, low on
// - overvoltage release only at next cycle
// - peak current ends high-side pulse
// - 512 clamped cycles trigger long hiccup
// - sourcing limit at cycle end skips pulse
// - resume high side at the first cycle start after sourcing limit clears
// - sinking limit turns everything off
// - low side back after high pulse
// - active only with supply and enable
// - enable low stops switching
module bsc_top
    import bsc_pkg::*;
#(
    parameter int HICCUP_CYC = HICCUP_CYC_DEF
)(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        PEAK_TRIP,
    input  wire logic        LS_SRC_LIM,
    input  wire logic        LS_SINK_LIM,
    input  wire logic        FB_ABOVE_108,
    input  wire logic        FB_BELOW_106,
    input  wire logic        BOOT_UV,
    input  wire logic        COMP_CLAMP_HI,
    input  wire logic        VIN_ABOVE_UNDERVOLTAGE_LOCKOUT,
    input  wire logic        EN_ABOVE_TH,
    input  wire logic        FREQ_SYNC_I,
    output logic             FREQ_SYNC_O,
    output logic             FREQ_SYNC_OE,
    output logic             HS_ON,
    output logic             LS_ON,
    output logic             DEV_ACTIVE
);

    localparam logic [14:0] HIC_LAST = 15'(HICCUP_CYC - 1);

    typedef struct packed {
        bsc_cmp_t    c1;
        bsc_cmp_t    c2;
        bsc_state_t  state;
        logic [2:0]  dead;
        logic [9:0]  clamp_cnt;
        logic [14:0] hic_cnt;
        logic        ovp_lock;
        logic        src_skip;
        logic        sink_block;
        logic        hs;
        logic        ls;
        logic        pin_oe;
        logic        active;
        logic        force_rt;
        logic [11:0] rt_period;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } bsc_top_st_t;

    bsc_top_st_t q;
    bsc_top_st_t n;
    bsc_cmp_t    cmp_in;
    logic        act;
    logic        cs;
    logic        hic_trip;
    logic        want_hs;
    logic        leave_hs;
    logic        setup;
    logic        access;
    logic [11:0] wr_period;
    logic [31:0] status;

    bsc_osc_if osc_if ();

    bsc_osc u_osc (
        .clk (REF_CLK),
        .rst (RST),
        .o   (osc_if)
    );

    assign osc_if.sync_raw  = FREQ_SYNC_I;
    assign osc_if.force_rt  = q.force_rt;
    assign osc_if.rt_period = q.rt_period;

    assign cmp_in = '{peak: PEAK_TRIP, src_lim: LS_SRC_LIM, sink_lim: LS_SINK_LIM,
                      overvoltage_guard: FB_ABOVE_108, below106: FB_BELOW_106, boot_uv: BOOT_UV,
                      clamp: COMP_CLAMP_HI, vin_ok: VIN_ABOVE_UNDERVOLTAGE_LOCKOUT, en_ok: EN_ABOVE_TH};

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        n        = q;
        // comparator flags are asynchronous: two stages before use
        n.c1     = cmp_in;
        n.c2     = q.c1;
        act      = q.c2.vin_ok & q.c2.en_ok;
        n.active = act;
        cs       = osc_if.cycle_start;
        hic_trip = 1'b0;

        if (q.c2.overvoltage_guard) begin
            n.ovp_lock = 1'b1;
        end else if (cs && q.c2.below106) begin
            n.ovp_lock = 1'b0;
        end

        if (cs) begin
            n.src_skip = q.c2.src_lim;
        end

        // clamp counter clears
        // no switching in hiccup, so clamped cycles there do not count
        if (!q.c2.clamp || (q.state == ST_HICCUP)) begin
            n.clamp_cnt = '0;
        end else if (cs) begin
            if (q.clamp_cnt == CLAMP_WAIT_CYC) begin
                hic_trip    = 1'b1;
                n.clamp_cnt = '0;
            end else begin
                n.clamp_cnt = 10'(q.clamp_cnt + 10'h001);
            end
        end

        want_hs  = ~q.c2.boot_uv & ~n.ovp_lock & ~n.src_skip;
        leave_hs = q.c2.boot_uv | n.ovp_lock | (q.c2.peak & ~osc_if.near_end) | (cs & ~want_hs);
        n.dead   = (q.dead != 3'h0) ? 3'(q.dead - 3'h1) : 3'h0;

        unique case (q.state)
            ST_IDLE: begin
                if (cs) begin
                    n.state = want_hs ? ST_HS : ST_LS;
                end
            end
            ST_HS: begin
                if (leave_hs) begin
                    n.state = ST_DT_HL;
                    n.dead  = DEAD_CYC;
                    n.sink_block = 1'b0;
                end
            end
            ST_DT_HL: begin
                if (q.dead == 3'h0) begin
                    n.state = ST_LS;
                end
            end
            ST_LS: begin
                if (q.c2.sink_lim && !q.c2.boot_uv) begin
                    n.state      = ST_NONE;
                    n.sink_block = 1'b1;
                end else if (cs && want_hs) begin
                    n.state = ST_DT_LH;
                    n.dead  = DEAD_CYC;
                end
            end
            ST_DT_LH: begin
                if (q.dead == 3'h0) begin
                    n.state = want_hs ? ST_HS : ST_LS;
                end
            end
            ST_NONE: begin
                if (q.c2.boot_uv) begin
                    n.state      = ST_LS;
                    n.sink_block = 1'b0;
                end else if (cs) begin
                    // both already off, so no extra dead time is needed
                    n.state = want_hs ? ST_HS : ST_NONE;
                end
            end
            ST_HICCUP: begin
                if (cs) begin
                    if (q.hic_cnt == HIC_LAST) begin
                        n.state = ST_IDLE;
                    end else begin
                        n.hic_cnt = 15'(q.hic_cnt + 15'h0001);
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase

        if (hic_trip) begin
            n.state   = ST_HICCUP;
            n.hic_cnt = '0;
        end
        if (!act) begin
            n.state      = ST_IDLE;
            n.clamp_cnt  = '0;
            n.hic_cnt    = '0;
            n.src_skip   = 1'b0;
            n.sink_block = 1'b0;
        end
        n.hs     = (n.state == ST_HS);
        n.ls     = (n.state == ST_LS);
        n.pin_oe = ~osc_if.ext_mode;

        // APB: zero wait states, read data captured in the setup cycle, write data taken in the access cycle
        setup     = PSEL & ~PENABLE;
        access    = PSEL & PENABLE & q.pready;
        n.pready  = setup;
        n.pslverr = setup & ~bsc_mapped(PADDR);
        status    = '0;
        status[STS_EXT]      = osc_if.ext_mode;
        status[STS_ACTIVE]   = q.active;
        status[STS_HICCUP]   = (q.state == ST_HICCUP);
        status[STS_OVP_LOCK] = q.ovp_lock;
        status[STS_SRC_SKIP] = q.src_skip;
        status[STS_SINK_BLK] = q.sink_block;
        status[STS_STATE_LSB +: $bits(bsc_state_t)] = q.state;
        if (setup) begin
            n.prdata = '0;
            if (!PWRITE) begin
                unique case (PADDR)
                    ADDR_CTRL:      n.prdata[CTRL_FORCE_RT] = q.force_rt;
                    ADDR_RT_PERIOD: n.prdata[11:0] = q.rt_period;
                    ADDR_STATUS:    n.prdata = status;
                    default:        n.prdata = '0;
                endcase
            end
        end
        wr_period = PWDATA[11:0];
        if (wr_period < PERIOD_MIN_CYC) begin
            wr_period = PERIOD_MIN_CYC;
        end else if (wr_period > PERIOD_MAX_CYC) begin
            wr_period = PERIOD_MAX_CYC;
        end
        if (access && PWRITE) begin
            if (PADDR == ADDR_CTRL) begin
                n.force_rt = PWDATA[CTRL_FORCE_RT];
            end else if (PADDR == ADDR_RT_PERIOD) begin
                n.rt_period = wr_period;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            q           <= '0;
            q.state     <= ST_IDLE;
            q.pin_oe    <= 1'b1;
            q.rt_period <= RT_PERIOD_RST;
        end else begin
            q <= n;
        end
    end

    assign PRDATA       = q.prdata;
    assign PREADY       = q.pready;
    assign PSLVERR      = q.pslverr;
    assign FREQ_SYNC_O  = 1'b0;
    assign FREQ_SYNC_OE = q.pin_oe;
    assign HS_ON        = q.hs;
    assign LS_ON        = q.ls;
    assign DEV_ACTIVE   = q.active;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // no cross conduction
    a_no_overlap : assert property (@(posedge REF_CLK) disable iff (RST)
        !(q.hs && q.ls))
        else $error("both switches on");

    a_dead_time : assert property (@(posedge REF_CLK) disable iff (RST)
        $fell(q.ls) |-> !q.hs ##1 !q.hs ##1 !q.hs)
        else $error("high side on inside dead time");

    a_ovp_hs_off : assert property (@(posedge REF_CLK) disable iff (RST)
        q.c2.overvoltage_guard |=> !q.hs)
        else $error("high side on during overvoltage");

    a_ovp_release : assert property (@(posedge REF_CLK) disable iff (RST)
        $rose(q.hs) |-> !q.ovp_lock)
        else $error("high side turned on under overvoltage lock");

    a_boot_uv_off : assert property (@(posedge REF_CLK) disable iff (RST)
        q.c2.boot_uv |=> !q.hs)
        else $error("high side on with bootstrap low");

    a_sink_cut : assert property (@(posedge REF_CLK) disable iff (RST)
        (q.ls && q.c2.sink_lim && !q.c2.boot_uv) |=> (!q.ls && !q.hs))
        else $error("low side kept on past sink limit");

    a_sink_hold : assert property (@(posedge REF_CLK) disable iff (RST)
        (q.state == ST_NONE && !q.c2.boot_uv) |=> !q.ls)
        else $error("low side back on before a high pulse");

    a_skip_blocks : assert property (@(posedge REF_CLK) disable iff (RST)
        $rose(q.hs) |-> !q.src_skip)
        else $error("high pulse while sourcing limit active");

    a_hiccup_entry : assert property (@(posedge REF_CLK) disable iff (RST)
        (q.state != ST_HICCUP) ##1 (q.state == ST_HICCUP) |-> $past(q.clamp_cnt) == CLAMP_WAIT_CYC)
        else $error("hiccup entered before wait count");

    a_clamp_clear : assert property (@(posedge REF_CLK) disable iff (RST)
        !q.c2.clamp |=> (q.clamp_cnt == 10'h000))
        else $error("clamp counter not cleared");

    a_inactive_off : assert property (@(posedge REF_CLK) disable iff (RST)
        !(q.c2.vin_ok && q.c2.en_ok) |=> (!q.hs && !q.ls && q.state == ST_IDLE))
        else $error("switching while inactive");

    a_period_range : assert property (@(posedge REF_CLK) disable iff (RST)
        (q.rt_period >= PERIOD_MIN_CYC) && (q.rt_period <= PERIOD_MAX_CYC))
        else $error("programmed period out of range");

    a_pin_release : assert property (@(posedge REF_CLK) disable iff (RST)
        osc_if.ext_mode |=> !FREQ_SYNC_OE)
        else $error("sync pin still driven in sync mode");

endmodule : bsc_top

// [bench/bsc_sync_src.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// far-side square-wave sync source
// ------------------------------------------------------------
module bsc_sync_src #(
    parameter int PERIOD_NS = 1000,
    parameter int HIGH_NS   = 300
)(
    input  wire logic run,
    output logic      lvl,
    output logic      drive
);
    // clock stands still and is released between bursts
    initial begin
        lvl   = 1'b0;
        drive = 1'b0;
        forever begin
            wait (run);
            // half a nanosecond keeps every edge off the sampling clock edge
            #0.5;
            drive = 1'b1;
            while (run) begin
                lvl = 1'b1;
                #(HIGH_NS);
                lvl = 1'b0;
                #(PERIOD_NS - HIGH_NS);
            end
            drive = 1'b0;
        end
    end
endmodule : bsc_sync_src

// [bench/buck_switch_cycle_supervisor_bench.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 4000) begin @(posedge REF_CLK); n++; end \
    if (n >= 4000) begin err_total++; complete_run(); end end
module buck_switch_cycle_supervisor_bench;
    import bsc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic w; logic [31:0] r; logic e;} bsc_row_t;
    logic        REF_CLK = 0, RST = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr   = 0;
    logic [31:0] pwdata  = 0, PRDATA, rd;
    logic        PREADY, PSLVERR, FREQ_SYNC_O, FREQ_SYNC_OE, HS_ON, LS_ON, DEV_ACTIVE, er;
    logic        peak = 0, sink = 0, clamp = 0, input_supply = 0, en = 0, s_run = 0, s_lvl, s_drv;
    logic [2:0]  flt = 0;
    int          err_total = 0, comparisons = 0, n, i;
    bsc_row_t    rows [7];
    wire         pin = s_drv ? s_lvl : (FREQ_SYNC_OE ? FREQ_SYNC_O : 1'b0);
    always #4 REF_CLK = ~REF_CLK;
    bsc_top #(.HICCUP_CYC(8)) uut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PEAK_TRIP(peak), .LS_SRC_LIM(flt[2]),
        .LS_SINK_LIM(sink), .FB_ABOVE_108(flt[1]), .FB_BELOW_106(~flt[1]), .BOOT_UV(flt[0]),
        .COMP_CLAMP_HI(clamp), .VIN_ABOVE_UNDERVOLTAGE_LOCKOUT(input_supply), .EN_ABOVE_TH(en), .FREQ_SYNC_I(pin),
        .FREQ_SYNC_O(FREQ_SYNC_O), .FREQ_SYNC_OE(FREQ_SYNC_OE), .HS_ON(HS_ON), .LS_ON(LS_ON),
        .DEV_ACTIVE(DEV_ACTIVE));
    // bench link clock: 125 ns period, 40% high
    bsc_sync_src #(.PERIOD_NS(125), .HIGH_NS(50)) src (.run(s_run), .lvl(s_lvl), .drive(s_drv));
    task automatic complete_run();
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge REF_CLK);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge REF_CLK);
        penable <= 1;
        k = 0;
        do begin @(posedge REF_CLK); k++; end while (PREADY !== 1'b1 && k < 50);
        if (k >= 50) begin err_total++; complete_run(); end
        rd = PRDATA; er = PSLVERR;
        psel <= 0; penable <= 0;
    endtask : apb
    always @(posedge REF_CLK) if (HS_ON === 1'b1) `CHK(LS_ON, 1'b0)
    initial begin
        rows = '{'{8'h04, 0, 0, 32'h0B3, 0}, '{8'h00, 0, 0, 0, 0},
                 '{8'h04, 32'h10, 1, 32'(PERIOD_MIN_CYC), 0},
                 '{8'h04, 32'hFFF, 1, 32'(PERIOD_MAX_CYC), 0}, '{8'h0C, 32'h55, 1, 0, 1},
                 '{8'h08, 32'h1, 1, 32'h100, 0}, '{8'h04, 32'h4F, 1, 32'h4F, 0}};
        repeat (10) @(posedge REF_CLK);
        RST <= 0;
        #1 `CHK({HS_ON, LS_ON, DEV_ACTIVE, FREQ_SYNC_OE, FREQ_SYNC_O}, 5'h02)
        foreach (rows[j]) begin
            if (rows[j].w) apb(rows[j].a, 1, rows[j].d);
            apb(rows[j].a, 0, 0);
            `CHK({rd, er}, {rows[j].r, rows[j].e})
        end
        input_supply <= 1;
        repeat (10) @(posedge REF_CLK);
        `CHK(DEV_ACTIVE, 1'b0)
        en <= 1;
        `WAIT(DEV_ACTIVE === 1'b1)
        `WAIT(HS_ON === 1'b1)
        peak <= 1;
        repeat (2) @(posedge REF_CLK);
        #1 `CHK(HS_ON, 1'b1)
        @(posedge REF_CLK);
        #1 `CHK(HS_ON, 1'b0)
        `WAIT(LS_ON === 1'b1)
        peak <= 0;
        for (i = 0; i < 3; i++) begin
            flt <= 3'(1 << i);
            repeat (3 * 79) @(posedge REF_CLK);
            `CHK({HS_ON, LS_ON}, 2'b01)
            flt <= 0;
            `WAIT(HS_ON === 1'b1)
        end
        peak <= 1;
        `WAIT(LS_ON === 1'b1)
        peak <= 0;
        sink <= 1;
        repeat (3) @(posedge REF_CLK);
        #1 `CHK({HS_ON, LS_ON}, 2'b00)
        sink <= 0;
        clamp <= 1;
        repeat (300 * 79) @(posedge REF_CLK);
        clamp <= 0;
        repeat (2 * 79) @(posedge REF_CLK);
        clamp <= 1;
        repeat (400 * 79) @(posedge REF_CLK);
        apb(ADDR_STATUS, 0, 0);
        `CHK(rd[STS_HICCUP], 1'b0)
        n = 0;
        do begin apb(ADDR_STATUS, 0, 0); n++; end while (rd[STS_HICCUP] !== 1'b1 && n < 4000);
        `CHK(rd[STS_HICCUP], 1'b1)
        `CHK({HS_ON, LS_ON}, 2'b00)
        clamp <= 0;
        s_run <= 1;
        `WAIT(FREQ_SYNC_OE === 1'b0)
        apb(ADDR_STATUS, 0, 0);
        `CHK(rd[STS_EXT], 1'b1)
        apb(ADDR_CTRL, 1, 32'h1);
        apb(ADDR_STATUS, 0, 0);
        `CHK(rd[STS_EXT], 1'b0)
        apb(ADDR_CTRL, 1, 32'h0);
        `WAIT(FREQ_SYNC_OE === 1'b0)
        s_run <= 0;
        repeat (1100) @(posedge REF_CLK);
        `CHK(FREQ_SYNC_OE, 1'b0)
        repeat (200) @(posedge REF_CLK);
        #1 `CHK(FREQ_SYNC_OE, 1'b1)
        en <= 0;
        repeat (4) @(posedge REF_CLK);
        #1 `CHK({DEV_ACTIVE, HS_ON, LS_ON}, 3'b000)
        complete_run();
    end
endmodule : buck_switch_cycle_supervisor_bench
